// *** pkg/ras_pkg.sv ***
// package: constants, states and carriers of the alarm match and serial slave block
package ras_pkg;
  // register offsets on the serial bus
  localparam logic [4:0] SEC_OFS = 5'h00;
  localparam logic [4:0] MIN_OFS = 5'h01;
  localparam logic [4:0] HOUR_OFS = 5'h02;
  localparam logic [4:0] DATE_OFS = 5'h03;
  localparam logic [4:0] MONTH_OFS = 5'h04;
  localparam logic [4:0] WDAY_OFS = 5'h06;
  localparam logic [4:0] STATUS_OFS = 5'h07;
  localparam logic [4:0] INTCTL_OFS = 5'h08;
  localparam logic [4:0] ALM1_OFS = 5'h0C;
  localparam logic [4:0] ALM_LAST_OFS = 5'h14;
  // alarm byte indexes inside the alarm store
  localparam int ALM1_N = 6;
  localparam int ALM_N = 9;
  localparam int A1_HOUR_IX = 2;
  localparam int A2_MIN_IX = 6;
  localparam int A2_HOUR_IX = 7;
  localparam int A2_DAY_IX = 8;
  // field positions
  localparam int EN_BIT = 7;
  localparam int FMT_BIT = 6;
  localparam int DAYSEL_BIT = 6;
  localparam int FLAG_AUTO_CLEAR_BIT = 7;
  localparam int A1F_BIT = 2;
  localparam int A2F_BIT = 1;
  localparam int FIRST_ALARM_ENABLE_BIT = 6;
  localparam int SECOND_ALARM_ENABLE_BIT = 5;
  localparam int FO_LSB = 3;
  localparam int PIN_INTERRUPT_SELECT_BIT = 2;
  localparam int A1E_BIT = 0;
  // reset values and bit counts
  localparam logic [1:0] FO_RST = 2'h3;
  localparam logic [2:0] SYNC_RST = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // serial slave states
  typedef enum logic [3:0] {
    RAS_IDLE, RAS_DEV, RAS_DEV_ACK, RAS_REG, RAS_REG_ACK,
    RAS_WR, RAS_WR_ACK, RAS_RD, RAS_RD_ACK
  } ras_i2c_e;

  // running clock fields, bcd bytes
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] wday;
  } ras_time_s;

  // state kept in the time counter domain
  typedef struct packed {
    logic tgl;
    ras_time_s hold;
  } ras_link_s;

  // state kept in the system clock domain
  typedef struct packed {
    ras_i2c_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic [4:0] ptr;
    logic sda_oe;
    logic armed;
    logic rd_stat;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] tgl_s;
    ras_time_s tm;
    logic eval;
    logic prev1;
    logic prev2;
    logic flag_auto_clear;
    logic a1f;
    logic a2f;
    logic first_alarm_enable;
    logic second_alarm_enable;
    logic [1:0] fo;
    logic pin_interrupt_select;
    logic a1e;
    logic [ALM_N-1:0][7:0] alm;
    logic irq_oe;
    logic pin_low;
  } ras_main_s;
endpackage

// *** verilog/ras_alarm_i2c.sv ***
// alarm match logic with its serial slave register access
//
// Contract
// - six first-alarm bytes, bit7 enables field
// - first alarm, no enables: fires every second
// - first alarm fires when enabled fields equal
// - enables map second..weekday in order
// - first flag cleared by zero write or autoclear
// - first match sets flag, pulls pin low
// - three second-alarm bytes, bit7 enables field
// - second alarm, no enables: fires at second 00
// - day byte selector picks weekday or date
// - second alarm fires when enabled fields equal
// - second match sets second flag
// - second flag cleared by zero write or autoclear
// - device is slave only, master clocks
// - bytes shifted most significant bit first
// - data changes only while clock low
// - data line released after power-up
// - wait for start; synchronisers reset to idle, so armed sets on the first cycle and starts count from the second cycle after reset
// - stop returns slave to standby
// - transmitter releases line after eight bits
// - acknowledge id, address and write data
// - alarms compare only while enabled, reset off
// - hour format mismatch blocks alarm
// - autoclear flags after status read and stop
// - only first alarm drives the pin
module ras_alarm_i2c #(
  parameter logic [6:0] DEV_ID = 7'h52 // arbitrary identifier value
) (
  // system clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // time counter domain
  input wire logic TCLK,
  input wire logic TIME_TICK,
  input wire ras_pkg::ras_time_s TIME,
  // serial bus pins
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // shared interrupt pin
  output logic IRQ_OUT,
  output logic IRQ_OE,
  // flag views
  output logic FIRST_ALARM_FLAG,
  output logic SECOND_ALARM_FLAG
);
  import ras_pkg::*;

  ras_link_s ql;
  ras_link_s dl;
  ras_main_s q;
  ras_main_s d;
  logic [ALM1_N-1:0][7:0] tv;
  logic [ALM1_N-1:0] en1;
  logic [ALM1_N-1:0] hit1;
  logic [2:0] hit2;
  logic fmt1_ok;
  logic fmt2_ok;
  logic m1;
  logic m2;
  logic trig1;
  logic trig2;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic clr1;
  logic clr2;
  logic [7:0] rbyte;

  // register read mux, unmapped offsets read zero
  function automatic logic [7:0] rd_byte(input ras_main_s s);
    logic [7:0] r;
    r = 8'h00;
    case (s.ptr)
      SEC_OFS: r = s.tm.sec;
      MIN_OFS: r = s.tm.min;
      HOUR_OFS: r = s.tm.hour;
      DATE_OFS: r = s.tm.date;
      MONTH_OFS: r = s.tm.month;
      WDAY_OFS: r = s.tm.wday;
      STATUS_OFS:
      begin
        r[FLAG_AUTO_CLEAR_BIT] = s.flag_auto_clear;
        r[A1F_BIT] = s.a1f;
        r[A2F_BIT] = s.a2f;
      end
      INTCTL_OFS:
      begin
        r[FIRST_ALARM_ENABLE_BIT] = s.first_alarm_enable;
        r[SECOND_ALARM_ENABLE_BIT] = s.second_alarm_enable;
        r[FO_LSB+:2] = s.fo;
        r[PIN_INTERRUPT_SELECT_BIT] = s.pin_interrupt_select;
        r[A1E_BIT] = s.a1e;
      end
      default:
      begin
        if (s.ptr >= ALM1_OFS && s.ptr <= ALM_LAST_OFS)
          r = s.alm[5'(s.ptr - ALM1_OFS)];
      end
    endcase
    return r;
  endfunction

  // time counter side: capture the new time and flip the event toggle
  always_comb
  begin
    dl = ql;
    if (TIME_TICK)
    begin
      dl.tgl = ~ql.tgl;
      dl.hold = TIME;
    end
  end

  always_ff @(posedge TCLK or negedge RSTN)
  begin
    if (!RSTN)
      ql <= '0;
    else
      ql <= dl;
  end

  // running fields as an array, second first
  assign tv = {q.tm.wday, q.tm.month, q.tm.date, q.tm.hour, q.tm.min, q.tm.sec};

  // per-field compare of the first alarm
  for (genvar gi = 0; gi < ALM1_N; gi++)
  begin : g_a1
    assign en1[gi] = q.alm[gi][EN_BIT];
    assign hit1[gi] = !en1[gi] || (q.alm[gi][6:0] == tv[gi][6:0]);
  end

  // first alarm match and trigger
  assign fmt1_ok = q.alm[A1_HOUR_IX][FMT_BIT] == q.tm.hour[FMT_BIT];
  assign m1 = q.first_alarm_enable && (&hit1) && fmt1_ok;
  assign trig1 = q.eval && m1 && (en1 == '0 || !q.prev1);

  // second alarm compares, day byte selects weekday or date
  assign hit2[0] = !q.alm[A2_MIN_IX][EN_BIT] ||
                   (q.alm[A2_MIN_IX][6:0] == q.tm.min[6:0]);
  assign hit2[1] = !q.alm[A2_HOUR_IX][EN_BIT] ||
                   (q.alm[A2_HOUR_IX][6:0] == q.tm.hour[6:0]);
  assign hit2[2] = !q.alm[A2_DAY_IX][EN_BIT] ||
                   (q.alm[A2_DAY_IX][DAYSEL_BIT] ?
                    (q.alm[A2_DAY_IX][2:0] == q.tm.wday[2:0]) :
                    (q.alm[A2_DAY_IX][5:0] == q.tm.date[5:0]));
  assign fmt2_ok = q.alm[A2_HOUR_IX][FMT_BIT] == q.tm.hour[FMT_BIT];
  // minute boundary only, so a bare enable fires once a minute
  assign m2 = q.second_alarm_enable && (&hit2) && fmt2_ok && (q.tm.sec == 8'h00);
  assign trig2 = q.eval && m2 && !q.prev2;

  // bus edges from the synchronised pins
  assign scl_rise = q.scl_s[1] && !q.scl_s[2];
  assign scl_fall = !q.scl_s[1] && q.scl_s[2];
  assign start_c = q.scl_s[1] && q.scl_s[2] && q.sda_s[2] && !q.sda_s[1];
  assign stop_c = q.scl_s[1] && q.scl_s[2] && !q.sda_s[2] && q.sda_s[1];
  assign rbyte = rd_byte(q);

  // next state of the system clock side
  always_comb
  begin
    d = q;
    clr1 = 1'b0;
    clr2 = 1'b0;
    d.scl_s = {q.scl_s[1:0], SCL};
    d.sda_s = {q.sda_s[1:0], SDA_IN};
    d.tgl_s = {q.tgl_s[1:0], ql.tgl};
    // new time word is stable for a whole second after its toggle
    d.eval = 1'b0;
    if (q.tgl_s[2] != q.tgl_s[1])
    begin
      d.tm = ql.hold;
      d.eval = 1'b1;
    end
    if (q.eval)
    begin
      d.prev1 = m1;
      d.prev2 = m2;
    end
    // starts count once the synchronised pins read idle, which their reset value already does
    if (q.scl_s[1] && q.sda_s[1])
      d.armed = 1'b1;
    if (stop_c)
    begin
      d.st = RAS_IDLE;
      d.sda_oe = 1'b0;
      d.rd_stat = 1'b0;
      if (q.rd_stat && q.flag_auto_clear)
      begin
        clr1 = 1'b1;
        clr2 = 1'b1;
      end
    end
    else if (start_c && q.armed)
    begin
      d.st = RAS_DEV;
      d.cnt = '0;
      d.sda_oe = 1'b0;
    end
    else
    begin
      case (q.st)
        RAS_DEV, RAS_REG, RAS_WR:
        begin
          if (scl_rise)
          begin
            d.sh = {q.sh[6:0], q.sda_s[1]};
            d.cnt = q.cnt + 4'h1;
          end
          else if (scl_fall && q.cnt == BYTE_BITS)
          begin
            // acknowledge is driven from the falling edge, clock low
            d.cnt = '0;
            d.sda_oe = 1'b1;
            if (q.st == RAS_DEV)
            begin
              if (q.sh[7:1] == DEV_ID)
              begin
                d.rw = q.sh[0];
                d.st = RAS_DEV_ACK;
              end
              else
              begin
                d.st = RAS_IDLE;
                d.sda_oe = 1'b0;
              end
            end
            else if (q.st == RAS_REG)
            begin
              d.ptr = q.sh[4:0];
              d.st = RAS_REG_ACK;
            end
            else
            begin
              case (q.ptr)
                STATUS_OFS:
                begin
                  d.flag_auto_clear = q.sh[FLAG_AUTO_CLEAR_BIT];
                  clr1 = !q.sh[A1F_BIT];
                  clr2 = !q.sh[A2F_BIT];
                end
                INTCTL_OFS:
                begin
                  d.first_alarm_enable = q.sh[FIRST_ALARM_ENABLE_BIT];
                  d.second_alarm_enable = q.sh[SECOND_ALARM_ENABLE_BIT];
                  d.fo = q.sh[FO_LSB+:2];
                  d.pin_interrupt_select = q.sh[PIN_INTERRUPT_SELECT_BIT];
                  d.a1e = q.sh[A1E_BIT];
                end
                default:
                begin
                  if (q.ptr >= ALM1_OFS && q.ptr <= ALM_LAST_OFS)
                    d.alm[5'(q.ptr - ALM1_OFS)] = q.sh;
                end
              endcase
              d.ptr = q.ptr + 5'h01;
              d.st = RAS_WR_ACK;
            end
          end
        end
        RAS_DEV_ACK, RAS_REG_ACK, RAS_WR_ACK:
        begin
          if (scl_fall)
          begin
            d.sda_oe = 1'b0;
            if (q.st == RAS_DEV_ACK && q.rw)
            begin
              d.sh = rbyte;
              d.sda_oe = !rbyte[7];
              d.cnt = '0;
              d.st = RAS_RD;
              if (q.ptr == STATUS_OFS)
                d.rd_stat = 1'b1;
            end
            else if (q.st == RAS_DEV_ACK)
              d.st = RAS_REG;
            else
              d.st = RAS_WR;
          end
        end
        RAS_RD:
        begin
          if (scl_fall)
          begin
            if (q.cnt == LAST_TX_BIT)
            begin
              d.sda_oe = 1'b0;
              d.st = RAS_RD_ACK;
              d.ptr = q.ptr + 5'h01;
            end
            else
            begin
              d.cnt = q.cnt + 4'h1;
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = !q.sh[6];
            end
          end
        end
        RAS_RD_ACK:
        begin
          if (scl_rise)
            d.mack = !q.sda_s[1];
          else if (scl_fall)
          begin
            if (q.mack)
            begin
              d.sh = rbyte;
              d.sda_oe = !rbyte[7];
              d.cnt = '0;
              d.st = RAS_RD;
              if (q.ptr == STATUS_OFS)
                d.rd_stat = 1'b1;
            end
            else
              d.st = RAS_IDLE;
          end
        end
        default:
        begin
          d.sda_oe = 1'b0;
        end
      endcase
    end
    // a new match wins over any clear in the same cycle
    d.a1f = trig1 || (q.a1f && !clr1);
    d.a2f = trig2 || (q.a2f && !clr2);
    // pin pulled low only for the first alarm in interrupt mode
    d.irq_oe = q.a1f && q.a1e && q.pin_interrupt_select && q.first_alarm_enable;
    d.pin_low = 1'b0;
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      q <= '0;
      q.scl_s <= SYNC_RST;
      q.sda_s <= SYNC_RST;
      q.fo <= FO_RST;
    end
    else
      q <= d;
  end

  // outputs straight from the state
  assign SDA_OUT = q.pin_low;
  assign SDA_OE = q.sda_oe;
  assign IRQ_OUT = q.pin_low;
  assign IRQ_OE = q.irq_oe;
  assign FIRST_ALARM_FLAG = q.a1f;
  assign SECOND_ALARM_FLAG = q.a2f;

  // checks
  sequence s_dev_ok;
    q.st == RAS_DEV && scl_fall && q.cnt == BYTE_BITS && q.sh[7:1] == DEV_ID;
  endsequence
  sequence s_ack_drive;
    q.sda_oe && q.st == RAS_DEV_ACK;
  endsequence
  property p_dev_ack;
    @(posedge MCLK) disable iff (!RSTN) s_dev_ok |=> s_ack_drive;
  endproperty
  a_dev_ack: assert property (p_dev_ack) else $error("id byte not acknowledged");

  property p_tx_release;
    @(posedge MCLK) disable iff (!RSTN)
      (q.st == RAS_RD && scl_fall && q.cnt == LAST_TX_BIT) |=> (!q.sda_oe && q.st == RAS_RD_ACK);
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("line held after byte");

  property p_msb_first;
    @(posedge MCLK) disable iff (!RSTN)
      (q.st == RAS_RD && scl_fall && q.cnt != LAST_TX_BIT && !stop_c) |=> (q.sda_oe == !q.sh[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("read bit order wrong");

  property p_idle_quiet;
    @(posedge MCLK) disable iff (!RSTN) (q.st == RAS_IDLE && !start_c) |=> !q.sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("data driven while idle");

  property p_stop_idle;
    @(posedge MCLK) disable iff (!RSTN) stop_c |=> (q.st == RAS_IDLE && !q.sda_oe);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle slave");

  property p_a1_every;
    @(posedge MCLK) disable iff (!RSTN) (q.eval && q.first_alarm_enable && en1 == '0 && fmt1_ok) |=> q.a1f;
  endproperty
  a_a1_every: assert property (p_a1_every) else $error("per-second alarm missed");

  property p_irq_pin;
    @(posedge MCLK) disable iff (!RSTN)
      (q.a1f && q.a1e && q.pin_interrupt_select && q.first_alarm_enable) |=> (IRQ_OE && !IRQ_OUT);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not pulled");

  property p_a2_boundary;
    @(posedge MCLK) disable iff (!RSTN) (q.eval && q.tm.sec != 8'h00 && !q.a2f) |=> !q.a2f;
  endproperty
  a_a2_boundary: assert property (p_a2_boundary) else $error("second alarm off boundary");

  property p_fmt;
    @(posedge MCLK) disable iff (!RSTN) (q.eval && !fmt1_ok && !q.a1f) |=> !q.a1f;
  endproperty
  a_fmt: assert property (p_fmt) else $error("alarm fired with format mismatch");

  property p_disabled;
    @(posedge MCLK) disable iff (!RSTN) (!q.first_alarm_enable && !q.a1f) |=> !q.a1f;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled alarm fired");

  property p_set_wins;
    @(posedge MCLK) disable iff (!RSTN) (trig1 && clr1) |=> q.a1f;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("match lost to clear");

  property p_autoclear;
    @(posedge MCLK) disable iff (!RSTN)
      (stop_c && q.rd_stat && q.flag_auto_clear && !trig1 && !trig2) |=> (!q.a1f && !q.a2f);
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("flags not auto cleared");

  property p_once;
    @(posedge MCLK) disable iff (!RSTN)
      (q.eval && q.prev1 && en1 != '0 && !q.a1f) |=> !q.a1f;
  endproperty
  a_once: assert property (p_once) else $error("held match set flag again");

  property p_a2_set;
    @(posedge MCLK) disable iff (!RSTN) trig2 |=> q.a2f;
  endproperty
  a_a2_set: assert property (p_a2_set) else $error("second flag not set");

endmodule // ras_alarm_i2c

// *** dv/ras_bus_master.sv ***
// serial bus master model driving the slave's clock and data pins
module ras_bus_master (
  // system clock paces the bus
  input wire logic MCLK,
  // slave pull-down enable
  input wire logic SDA_OE,
  // bus pins seen by the slave
  output logic SCL,
  output logic SDA_IN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic m_sda;
  // open-drain data wire with pull-up: low while either party pulls
  assign SDA_IN = m_sda & ~SDA_OE;
  // bus idles high until the master opens a frame
  initial
  begin
    SCL = 1'b1;
    m_sda = 1'b1;
  end
  // half bit time, well past the slave's synchroniser delay
  task automatic hp();
    repeat (8) @(negedge MCLK);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    hp();
    m_sda = 1'b1;
    hp();
    SCL = 1'b1;
    hp();
    m_sda = 1'b0;
    hp();
    SCL = 1'b0;
  endtask
  // stop: data rises while clock high, closing the frame
  task automatic stop();
    hp();
    m_sda = 1'b0;
    hp();
    SCL = 1'b1;
    hp();
    m_sda = 1'b1;
    hp();
  endtask
  // one clock pulse; data set while clock low, sampled while high
  task automatic bit1(input logic b, output logic r);
    repeat (2) @(negedge MCLK);
    m_sda = b;
    hp();
    SCL = 1'b1;
    hp();
    r = SDA_IN;
    SCL = 1'b0;
  endtask
  // byte out, then line released for the slave's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit1(d[i], r);
    bit1(1'b1, r);
    ack = ~r;
  endtask
  // byte in; low acknowledge asks for more, high ends the read
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit1(1'b1, d[i]);
    bit1(last, r);
  endtask
endmodule // ras_bus_master

// *** dv/test_rtc_alarm_match_i2c_slave.sv ***
// self-checking bench for the alarm match block and its serial slave
module test_rtc_alarm_match_i2c_slave import ras_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ID = 7'h2B; // arbitrary identifier value
  localparam int LIMIT = 60000;
  logic mclk = 1'b0;
  logic tclk = 1'b0;
  logic rstn = 1'b0;
  logic time_tick = 1'b0;
  ras_time_s tnow = '0;
  logic scl, sda_in, sda_oe, irq_oe, f1, f2;
  logic sda_out, irq_out;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] rq[$];
  logic [5:0][7:0] base = 48'h01_01_01_01_01_01;
  // system clock and a time clock unrelated in phase
  always #20 mclk = ~mclk;
  initial #7 forever #62.5 tclk = ~tclk;
  // design and bus master
  ras_alarm_i2c #(.DEV_ID(ID)) DUT (.MCLK(mclk), .RSTN(rstn), .TCLK(tclk),
    .TIME_TICK(time_tick), .TIME(tnow), .SCL(scl), .SDA_IN(sda_in),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .IRQ_OUT(irq_out), .IRQ_OE(irq_oe),
    .FIRST_ALARM_FLAG(f1), .SECOND_ALARM_FLAG(f2));
  ras_bus_master bus (.MCLK(mclk), .SDA_OE(sda_oe), .SCL(scl), .SDA_IN(sda_in));
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // pin and flags as {irq, first, second}; open-drain output levels must stay low
  task automatic pins(input logic [2:0] e);
    chk({3'h0, sda_out, irq_out, irq_oe, f1, f2}, {5'h0, e});
  endtask
  // write bytes from an offset in one frame
  task automatic wr(input logic [4:0] a, input logic [7:0] q[$]);
    logic k;
    bus.start();
    bus.wbyte({ID, 1'b0}, k);
    chk({7'h0, k}, 8'h01);
    bus.wbyte({3'h0, a}, k);
    chk({7'h0, k}, 8'h01);
    foreach (q[i])
    begin
      bus.wbyte(q[i], k);
      chk({7'h0, k}, 8'h01);
    end
    bus.stop();
  endtask
  // random read of n bytes into rq
  task automatic rd(input logic [4:0] a, input int n);
    logic k;
    logic [7:0] d;
    rq = {};
    bus.start();
    bus.wbyte({ID, 1'b0}, k);
    bus.wbyte({3'h0, a}, k);
    bus.start();
    bus.wbyte({ID, 1'b1}, k);
    chk({7'h0, k}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      bus.rbyte(i == n - 1, d);
      rq.push_back(d);
    end
    bus.stop();
  endtask
  // new running time on a time clock edge, then settle
  task automatic tk(input logic [5:0][7:0] v);
    @(negedge tclk);
    tnow = v;
    time_tick = 1'b1;
    @(negedge tclk);
    time_tick = 1'b0;
    repeat (12) @(negedge mclk);
  endtask
  // base time with field i (0 = second) replaced
  function automatic logic [5:0][7:0] fld(input int i, input logic [7:0] x);
    logic [5:0][7:0] v;
    v = base;
    v[5 - i] = x;
    return v;
  endfunction
  // all alarm bytes to zero
  task automatic zap();
    logic [7:0] z[$];
    repeat (ALM_N) z.push_back(8'h00);
    wr(ALM1_OFS, z);
  endtask
  task automatic t_reset();
    pins(3'h0);
    chk({7'h0, sda_oe}, 8'h00);
    rd(INTCTL_OFS, 1);
    chk(rq[0], 8'h18);
    tk(base);
    pins(3'h0);
    $display("reset test done");
  endtask
  task automatic t_id();
    logic k;
    bus.start();
    bus.wbyte({~ID, 1'b0}, k);
    chk({7'h0, k}, 8'h00);
    bus.stop();
    $display("id test done");
  endtask
  task automatic t_regs();
    logic [7:0] p[$];
    for (int i = 0; i < ALM_N; i++)
      p.push_back(8'h81 + 8'(i * 13));
    wr(ALM1_OFS, p);
    rd(ALM1_OFS, ALM_N);
    foreach (p[i])
      chk(rq[i], p[i]);
    zap();
    $display("register test done");
  endtask
  task automatic t_every();
    wr(INTCTL_OFS, '{8'h45});
    tk(base);
    pins(3'h6);
    wr(STATUS_OFS, '{8'h00});
    pins(3'h0);
    tk(base);
    pins(3'h6);
    $display("every second test done");
  endtask
  task automatic t_fields();
    logic [7:0] q[$];
    for (int i = 0; i < ALM1_N; i++)
    begin
      q = {};
      for (int j = 0; j < ALM1_N; j++)
        q.push_back(j == i ? 8'h85 : 8'h00);
      wr(ALM1_OFS, q);
      wr(STATUS_OFS, '{8'h00});
      tk(base);
      pins(3'h0);
      tk(fld(i, 8'h05));
      pins(3'h6);
      wr(STATUS_OFS, '{8'h00});
      tk(fld(i, 8'h05));
      pins(3'h0);
    end
    zap();
    wr(5'h0E, '{8'h85});
    tk(base);
    tk(fld(2, 8'h45));
    pins(3'h0);
    tk(fld(2, 8'h05));
    pins(3'h6);
    $display("field test done");
  endtask
  task automatic t_second();
    logic [5:0][7:0] v;
    zap();
    wr(STATUS_OFS, '{8'h00});
    wr(INTCTL_OFS, '{8'h20});
    tk(base);
    pins(3'h0);
    v = fld(0, 8'h00);
    tk(v);
    pins(3'h1);
    wr(STATUS_OFS, '{8'h00});
    pins(3'h0);
    wr(5'h14, '{8'hC3});
    tk(v);
    pins(3'h0);
    v[0] = 8'h03;
    tk(v);
    pins(3'h1);
    wr(STATUS_OFS, '{8'h00});
    wr(5'h14, '{8'h83});
    tk(v);
    pins(3'h0);
    v[2] = 8'h03;
    tk(v);
    pins(3'h1);
    $display("second alarm test done");
  endtask
  task automatic t_auto();
    logic [5:0][7:0] v;
    wr(STATUS_OFS, '{8'h80});
    wr(INTCTL_OFS, '{8'h65});
    v = fld(3, 8'h03);
    tk(v);
    pins(3'h6);
    v[5] = 8'h00;
    tk(v);
    pins(3'h7);
    rd(STATUS_OFS, 1);
    chk(rq[0], 8'h86);
    repeat (4) @(negedge mclk);
    pins(3'h0);
    $display("auto clear test done");
  endtask
  // counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      bad_count++;
      test_done();
    end
  end
  // reset, then the scenarios
  initial
  begin
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    repeat (10) @(negedge mclk);
    t_reset();
    t_id();
    t_regs();
    t_every();
    t_fields();
    t_second();
    t_auto();
    test_done();
  end
endmodule // test_rtc_alarm_match_i2c_slave
